// ==== dcu_datapath.sv ====
// Data computation datapath: shifter, 40-bit ALU, two MACs, accumulators,
// transition registers and the 16-bit address-unit ALU
// Assumes commands and operands arrive from decoder logic on clk_sys
`timescale 1ns/1ns
`default_nettype none
`include "dcu_consts.svh"
// Behaviour
// - Accumulator shifts left up to 31 or right up to 32, count constant or temporary
// - 16-bit register, memory or I/O operand shifts with the same range and sources
// - Immediate on the DCU_SH_IMM source shifts left only, at most 15 positions, count constant or temporary
// - Without a constant, the count comes from one of four temporary registers
// - Normalizes accumulators, extracts and expands bit fields, counts bits
// - Rotates register values; rounds and saturates accumulators on the store path
// - Shifter result feeds the 40-bit ALU and the address-unit ALU
// - 40-bit ALU adds, subtracts, compares, rounds, saturates, logic, absolute value
// - Dual 16-bit instruction does two independent 16-bit operations in one cycle
// - ALU tests, sets, clears, complements accumulator bits and moves values
// - Each MAC multiplies 17x17, fractional or integer, within one cycle
// - Each MAC adds or subtracts 40 bits same cycle, optional 32/40 saturation
// - MAC results go only to accumulators
// - MAC operations update overflow status bits
// - MACs take immediate, memory, I/O and address-unit operands
// - Four accumulators, loadable from many sources, read by shifter, ALU, MACs
// - Two transition registers linked both ways with shifter and ALU; MACs neither read nor write them
// - Address-unit ALU is 16 bits and takes immediates and other operands
// - Address-unit ALU adds, subtracts, compares, logic, shifts, absolute value
// - Address-unit ALU tests, sets, clears, complements single bits
// - Address-unit ALU takes shifter results, rotates and moves values
module dcu_datapath (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire dcu_pkg::dcu_op_t du_op,
  input wire logic [1:0] dst_sel,
  input wire logic [1:0] srca_sel,
  input wire logic [1:0] srcb_sel,
  input wire dcu_pkg::dcu_bsel_t b_sel,
  input wire dcu_pkg::dcu_shsrc_t sh_src,
  input wire dcu_pkg::dcu_osel_t opnd_sel,
  input wire logic [15:0] imm16,
  input wire logic [15:0] mem16,
  input wire logic [15:0] areg16,
  input wire logic [15:0] preg16,
  input wire logic shift_const_en,
  input wire logic [6:0] shift_const,
  input wire logic [1:0] tcnt_sel,
  input wire logic [3:0][15:0] temporary_shift_count_regs,
  input wire logic sat_en,
  input wire logic sat32,
  input wire logic [5:0] bit_idx,
  input wire logic [1:0][15:0] mac_x,
  input wire logic [1:0][15:0] mac_y,
  input wire logic [1:0][1:0] mac_dst,
  input wire logic mac_uns,
  input wire logic mac_frac,
  input wire logic store_en,
  input wire logic [1:0] store_sel,
  input wire logic store_rnd,
  input wire logic store_sat,
  input wire logic au_valid,
  input wire dcu_pkg::dcu_au_op_t au_op,
  input wire logic [15:0] au_a,
  input wire logic [3:0] au_bit,
  input wire logic [3:0] ovf_clr,
  output logic [3:0][39:0] accumulator_bank,
  output logic [15:0] transition_reg_zero,
  output logic [15:0] transition_reg_one,
  output logic [15:0] store_data,
  output logic store_valid,
  output logic [15:0] au_shift_data,
  output logic [15:0] au_result,
  output logic au_result_valid,
  output logic au_tc,
  output logic du_tc,
  output logic du_carry,
  output logic [3:0] status_ovf
);
  logic [3:0][39:0] acc_reg, acc_next;
  logic [1:0][15:0] trn_reg, trn_next;
  logic tc_reg, tc_next, carry_reg, carry_next;
  logic [3:0] ovf_reg, ovf_next, ovf_set;
  logic [15:0] st_reg, st_next, aush_reg, aush_next;
  logic st_vld_reg, st_vld_next;
  logic [15:0] aur_reg, aur_next;
  logic aur_vld_reg, aur_vld_next, autc_reg, autc_next;
  logic [15:0] opnd16, tval, craw;
  logic signed [6:0] shcnt, negc;
  logic [39:0] sh_in, shf_res, a_op, b_op, st_v, rnd_v;
  logic [40:0] alu_sum, alu_dif, alu_neg, alu_rnd, st_sum;
  logic [15:0] dual_hi, dual_lo, shf_au;
  logic [4:0] norm_sh;
  logic [5:0] sign_n, pop_n;
  logic [1:0][39:0] mac_out;
  logic [1:0] mac_ovf;

  function automatic logic [5:0] dcu_sign_bits(input logic [39:0] v);
    logic [5:0] n;
    logic run;
    n = 6'h00;
    run = 1'b1;
    for (int i = 38; i >= 0; i--) begin
      if (run && (v[i] == v[39])) n = n + 6'h01;
      else run = 1'b0;
    end
    return n;
  endfunction : dcu_sign_bits

  function automatic logic [5:0] dcu_popcount(input logic [39:0] v);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < 40; i++) n = n + {5'h00, v[i]};
    return n;
  endfunction : dcu_popcount

  function automatic logic [15:0] dcu_field(input logic [15:0] v, input logic [15:0] m, input logic expand);
    logic [15:0] r;
    logic [4:0] k;
    r = 16'h0000;
    k = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (m[i]) begin
        if (expand) r[i] = v[k[3:0]];
        else r[k[3:0]] = v[i];
        k = k + 5'h01;
      end
    end
    return r;
  endfunction : dcu_field

  // Shifter
  always_comb begin
    case (opnd_sel)
      dcu_pkg::DCU_O_IMM: opnd16 = imm16;
      dcu_pkg::DCU_O_MEM: opnd16 = mem16;
      dcu_pkg::DCU_O_AREG: opnd16 = areg16;
      default: opnd16 = preg16;
    endcase
    tval = temporary_shift_count_regs[tcnt_sel];
    craw = shift_const_en ? {{9{shift_const[6]}}, shift_const} : tval;
    if ($signed(craw) > `DCU_SHL_MAX) shcnt = 7'sh1f;
    else if ($signed(craw) < `DCU_SHR_MAX) shcnt = 7'sh60;
    else shcnt = craw[6:0];
    case (sh_src)
      dcu_pkg::DCU_SH_ACC: sh_in = acc_reg[srca_sel];
      dcu_pkg::DCU_SH_OP16: sh_in = {{24{opnd16[15]}}, opnd16};
      dcu_pkg::DCU_SH_IMM: sh_in = {{24{imm16[15]}}, imm16};
      default: sh_in = {{24{trn_reg[srca_sel[0]][15]}}, trn_reg[srca_sel[0]]};
    endcase
    if (sh_src == dcu_pkg::DCU_SH_IMM) begin
      if (shcnt < `DCU_CNT_ZERO) shcnt = `DCU_CNT_ZERO;
      else if (shcnt > `DCU_IMM_SHL_MAX) shcnt = `DCU_IMM_SHL_MAX;
    end
    negc = -shcnt;
    if (shcnt[6]) shf_res = $signed(sh_in) >>> negc[5:0];
    else shf_res = sh_in << shcnt[4:0];
  end

  // 40-bit ALU operands and intermediate results
  always_comb begin
    a_op = acc_reg[srca_sel];
    case (b_sel)
      dcu_pkg::DCU_B_ACC: b_op = acc_reg[srcb_sel];
      dcu_pkg::DCU_B_SHF: b_op = shf_res;
      dcu_pkg::DCU_B_OP16: b_op = {{24{opnd16[15]}}, opnd16};
      default: b_op = {{24{trn_reg[srcb_sel[0]][15]}}, trn_reg[srcb_sel[0]]};
    endcase
    alu_sum = {a_op[39], a_op} + {b_op[39], b_op};
    alu_dif = {a_op[39], a_op} - {b_op[39], b_op};
    alu_neg = 41'h00000000000 - {a_op[39], a_op};
    alu_rnd = {a_op[39], a_op} + `DCU_RND_ADD;
    dual_hi = (du_op == dcu_pkg::DCU_DSUB) ? a_op[31:16] - b_op[31:16] : a_op[31:16] + b_op[31:16];
    dual_lo = (du_op == dcu_pkg::DCU_DSUB) ? a_op[15:0] - b_op[15:0] : a_op[15:0] + b_op[15:0];
    sign_n = dcu_sign_bits(a_op);
    norm_sh = (sign_n > `DCU_NORM_MAX) ? 5'h1f : sign_n[4:0];
    pop_n = dcu_popcount(a_op & b_op);
    case (du_op)
      dcu_pkg::DCU_NORM: shf_au = {11'h000, norm_sh};
      dcu_pkg::DCU_BCNT: shf_au = {10'h000, pop_n};
      default: shf_au = shf_res[15:0];
    endcase
  end

  // Multiply-accumulate units
  for (genvar k = 0; k < 2; k++) begin : g_mac
    logic [16:0] mx, my;
    logic [39:0] macc;
    assign mx = {~mac_uns & mac_x[k][15], mac_x[k]};
    assign my = {~mac_uns & mac_y[k][15], mac_y[k]};
    assign macc = (du_op == dcu_pkg::DCU_MPY) ? `DCU_ACC_RST : acc_reg[mac_dst[k]];
    dcu_mac u_mac (
      .mul_x(mx),
      .mul_y(my),
      .frac_mode(mac_frac),
      .sub_mode(du_op == dcu_pkg::DCU_MAS),
      .sat_en(sat_en),
      .sat32(sat32),
      .acc_in(macc),
      .mac_out(mac_out[k]),
      .mac_ovf(mac_ovf[k])
    );
  end

  // Computation-unit register state
  always_comb begin
    acc_next = acc_reg;
    trn_next = trn_reg;
    tc_next = tc_reg;
    carry_next = carry_reg;
    ovf_set = 4'h0;
    aush_next = aush_reg;
    if (cmd_valid) begin
      aush_next = shf_au;
      case (du_op)
        dcu_pkg::DCU_SHIFT: acc_next[dst_sel] = shf_res;
        dcu_pkg::DCU_ADD: begin
          acc_next[dst_sel] = sat_en ? dcu_pkg::dcu_sat(alu_sum, sat32) : alu_sum[39:0];
          ovf_set[dst_sel] = alu_sum[40] ^ alu_sum[39];
          carry_next = ({1'b0, a_op} + {1'b0, b_op}) > 41'h0ffffffffff;
        end
        dcu_pkg::DCU_SUB: begin
          acc_next[dst_sel] = sat_en ? dcu_pkg::dcu_sat(alu_dif, sat32) : alu_dif[39:0];
          ovf_set[dst_sel] = alu_dif[40] ^ alu_dif[39];
          carry_next = (a_op >= b_op);
        end
        dcu_pkg::DCU_CMP: tc_next = (a_op == b_op);
        dcu_pkg::DCU_RND:
          acc_next[dst_sel] = (sat_en ? dcu_pkg::dcu_sat(alu_rnd, sat32) : alu_rnd[39:0]) & `DCU_RND_MASK;
        dcu_pkg::DCU_SAT: acc_next[dst_sel] = dcu_pkg::dcu_sat({a_op[39], a_op}, 1'b1);
        dcu_pkg::DCU_AND: acc_next[dst_sel] = a_op & b_op;
        dcu_pkg::DCU_OR: acc_next[dst_sel] = a_op | b_op;
        dcu_pkg::DCU_XOR: acc_next[dst_sel] = a_op ^ b_op;
        dcu_pkg::DCU_ABS: begin
          if (a_op[39]) acc_next[dst_sel] = sat_en ? dcu_pkg::dcu_sat(alu_neg, sat32) : alu_neg[39:0];
          else acc_next[dst_sel] = a_op;
        end
        dcu_pkg::DCU_DADD, dcu_pkg::DCU_DSUB: acc_next[dst_sel] = {{8{dual_hi[15]}}, dual_hi, dual_lo};
        dcu_pkg::DCU_BTST: begin
          if (bit_idx < `DCU_BIT_LIMIT) tc_next = a_op[bit_idx];
        end
        dcu_pkg::DCU_BSET: begin
          if (bit_idx < `DCU_BIT_LIMIT) acc_next[dst_sel][bit_idx] = 1'b1;
        end
        dcu_pkg::DCU_BCLR: begin
          if (bit_idx < `DCU_BIT_LIMIT) acc_next[dst_sel][bit_idx] = 1'b0;
        end
        dcu_pkg::DCU_BNOT: begin
          if (bit_idx < `DCU_BIT_LIMIT) acc_next[dst_sel][bit_idx] = ~acc_reg[dst_sel][bit_idx];
        end
        dcu_pkg::DCU_MOV: acc_next[dst_sel] = b_op;
        dcu_pkg::DCU_TRN: trn_next[dst_sel[0]] = b_op[15:0];
        dcu_pkg::DCU_MAC, dcu_pkg::DCU_MAS, dcu_pkg::DCU_MPY: begin
          for (int k = 0; k < 2; k++) begin
            acc_next[mac_dst[k]] = mac_out[k];
            ovf_set[mac_dst[k]] = ovf_set[mac_dst[k]] | mac_ovf[k];
          end
        end
        dcu_pkg::DCU_NORM: acc_next[dst_sel] = a_op << norm_sh;
        dcu_pkg::DCU_EXTR: acc_next[dst_sel] = {24'h000000, dcu_field(a_op[15:0], imm16, 1'b0)};
        dcu_pkg::DCU_EXPD: acc_next[dst_sel] = {24'h000000, dcu_field(a_op[15:0], imm16, 1'b1)};
        dcu_pkg::DCU_BCNT: tc_next = pop_n[0];
        dcu_pkg::DCU_ROT: begin
          acc_next[dst_sel] = {a_op[38:0], carry_reg};
          carry_next = a_op[39];
        end
        default: ;
      endcase
    end
    ovf_next = (ovf_reg & ~ovf_clr) | ovf_set;
  end

  // Store path with rounding and saturation
  always_comb begin
    st_v = acc_reg[store_sel];
    st_sum = {st_v[39], st_v} + `DCU_RND_ADD;
    rnd_v = store_rnd ? st_sum[39:0] : st_v;
    if (store_sat) rnd_v = dcu_pkg::dcu_sat(store_rnd ? st_sum : {st_v[39], st_v}, 1'b1);
    st_next = store_en ? rnd_v[31:16] : st_reg;
    st_vld_next = store_en;
  end

  // Address-unit ALU
  always_comb begin
    aur_next = aur_reg;
    autc_next = autc_reg;
    aur_vld_next = au_valid;
    if (au_valid) begin
      case (au_op)
        dcu_pkg::DCU_AU_ADD: aur_next = au_a + opnd16;
        dcu_pkg::DCU_AU_SUB: aur_next = au_a - opnd16;
        dcu_pkg::DCU_AU_CMP: autc_next = (au_a == opnd16);
        dcu_pkg::DCU_AU_AND: aur_next = au_a & opnd16;
        dcu_pkg::DCU_AU_OR: aur_next = au_a | opnd16;
        dcu_pkg::DCU_AU_XOR: aur_next = au_a ^ opnd16;
        dcu_pkg::DCU_AU_SHL: aur_next = au_a << opnd16[3:0];
        dcu_pkg::DCU_AU_SHRA: aur_next = $signed(au_a) >>> opnd16[3:0];
        dcu_pkg::DCU_AU_SHRL: aur_next = au_a >> opnd16[3:0];
        dcu_pkg::DCU_AU_ABS: begin
          if (au_a == `DCU_AU_NEG16) aur_next = `DCU_AU_POS16;
          else aur_next = au_a[15] ? 16'h0000 - au_a : au_a;
        end
        dcu_pkg::DCU_AU_BTST: autc_next = au_a[au_bit];
        dcu_pkg::DCU_AU_BSET: aur_next = au_a | (16'h0001 << au_bit);
        dcu_pkg::DCU_AU_BCLR: aur_next = au_a & ~(16'h0001 << au_bit);
        dcu_pkg::DCU_AU_BNOT: aur_next = au_a ^ (16'h0001 << au_bit);
        dcu_pkg::DCU_AU_ROT: aur_next = {au_a[14:0], au_a[15]};
        dcu_pkg::DCU_AU_MOV: aur_next = opnd16;
        dcu_pkg::DCU_AU_SHFT: aur_next = shf_au;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= {4{`DCU_ACC_RST}};
      trn_reg <= {2{`DCU_HALF_RST}};
      tc_reg <= 1'b0;
      carry_reg <= 1'b0;
      ovf_reg <= 4'h0;
      aush_reg <= `DCU_HALF_RST;
      st_reg <= `DCU_HALF_RST;
      st_vld_reg <= 1'b0;
      aur_reg <= `DCU_HALF_RST;
      aur_vld_reg <= 1'b0;
      autc_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      trn_reg <= trn_next;
      tc_reg <= tc_next;
      carry_reg <= carry_next;
      ovf_reg <= ovf_next;
      aush_reg <= aush_next;
      st_reg <= st_next;
      st_vld_reg <= st_vld_next;
      aur_reg <= aur_next;
      aur_vld_reg <= aur_vld_next;
      autc_reg <= autc_next;
    end
  end

  assign accumulator_bank = acc_reg;
  assign transition_reg_zero = trn_reg[0];
  assign transition_reg_one = trn_reg[1];
  assign store_data = st_reg;
  assign store_valid = st_vld_reg;
  assign au_shift_data = aush_reg;
  assign au_result = aur_reg;
  assign au_result_valid = aur_vld_reg;
  assign au_tc = autc_reg;
  assign du_tc = tc_reg;
  assign du_carry = carry_reg;
  assign status_ovf = ovf_reg;

  chk_acc_shl_one: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cmd_valid && du_op == dcu_pkg::DCU_SHIFT && sh_src == dcu_pkg::DCU_SH_ACC && shift_const_en
     && shift_const == 7'h01 && dst_sel == 2'h0 && srca_sel == 2'h0)
    |=> acc_reg[0] == {$past(acc_reg[0][38:0]), 1'b0})
    else $error("accumulator left shift by one wrong");
  chk_acc_shr_max: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cmd_valid && du_op == dcu_pkg::DCU_SHIFT && sh_src == dcu_pkg::DCU_SH_ACC && shift_const_en
     && shift_const == 7'h60 && dst_sel == 2'h0 && srca_sel == 2'h0)
    |=> acc_reg[0] == {{32{$past(acc_reg[0][39])}}, $past(acc_reg[0][39:32])})
    else $error("accumulator right shift by 32 wrong");
  chk_imm_left_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cmd_valid && du_op == dcu_pkg::DCU_SHIFT && sh_src == dcu_pkg::DCU_SH_IMM && shift_const_en
     && shift_const[6] && dst_sel == 2'h0)
    |=> acc_reg[0] == {{24{$past(imm16[15])}}, $past(imm16)})
    else $error("immediate shifted right");
  chk_tcount_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cmd_valid && du_op == dcu_pkg::DCU_SHIFT && sh_src == dcu_pkg::DCU_SH_ACC && !shift_const_en
     && temporary_shift_count_regs[tcnt_sel] == 16'h0001 && dst_sel == 2'h1 && srca_sel == 2'h1)
    |=> acc_reg[1] == {$past(acc_reg[1][38:0]), 1'b0})
    else $error("temporary shift count not applied");
  chk_dual_add_lanes: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cmd_valid && du_op == dcu_pkg::DCU_DADD && b_sel == dcu_pkg::DCU_B_ACC && dst_sel == 2'h0
     && srca_sel == 2'h0 && srcb_sel == 2'h1)
    |=> acc_reg[0][15:0] == $past(acc_reg[0][15:0]) + $past(acc_reg[1][15:0])
        && acc_reg[0][31:16] == $past(acc_reg[0][31:16]) + $past(acc_reg[1][31:16]))
    else $error("dual add lanes wrong");
  chk_mac_int_mpy: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cmd_valid && du_op == dcu_pkg::DCU_MPY && !mac_frac && !mac_uns && !sat_en
     && mac_dst[0] == 2'h2 && mac_dst[1] == 2'h3)
    |=> $signed(acc_reg[2]) == $signed($past(mac_x[0])) * $signed($past(mac_y[0])))
    else $error("integer multiply result wrong");
  chk_mac_only_acc: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cmd_valid && du_op == dcu_pkg::DCU_MAC)
    |=> trn_reg == $past(trn_reg) && acc_reg[$past(mac_dst[1])] == $past(mac_out[1]))
    else $error("multiply-accumulate result misrouted");
  chk_mac_ovf_flag: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cmd_valid && du_op == dcu_pkg::DCU_MAC && mac_ovf[0]) |=> status_ovf[$past(mac_dst[0])])
    else $error("overflow status not set");
  chk_sat_clamp40: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (cmd_valid && du_op == dcu_pkg::DCU_ADD && sat_en && !sat32 && dst_sel == 2'h0
     && (alu_sum[40] != alu_sum[39]))
    |=> acc_reg[0] == ($past(alu_sum[40]) ? `DCU_NEG40 : `DCU_POS40))
    else $error("40-bit saturation wrong");
  chk_au_takes_shf: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (au_valid && au_op == dcu_pkg::DCU_AU_SHFT && du_op == dcu_pkg::DCU_SHIFT)
    |=> au_result == $past(shf_res[15:0]) && au_result_valid)
    else $error("shifter result not moved to address unit");
endmodule : dcu_datapath
`default_nettype wire

// ==== dcu_consts.svh ====
// Constants of the data computation datapath
// Assumes inclusion by its bare name, once per compile unit or guarded
`ifndef DCU_CONSTS_SVH
`define DCU_CONSTS_SVH
`define DCU_SHL_MAX 16'sh001f
`define DCU_SHR_MAX 16'shffe0
`define DCU_IMM_SHL_MAX 7'sh0f
`define DCU_CNT_ZERO 7'sh00
`define DCU_NORM_MAX 6'h1f
`define DCU_BIT_LIMIT 6'h28
`define DCU_RND_ADD 41'h00000008000
`define DCU_RND_MASK 40'hffffff0000
`define DCU_POS40 40'h7fffffffff
`define DCU_NEG40 40'h8000000000
`define DCU_POS32 40'h007fffffff
`define DCU_NEG32 40'hff80000000
`define DCU_ACC_RST 40'h0000000000
`define DCU_HALF_RST 16'h0000
`define DCU_AU_POS16 16'h7fff
`define DCU_AU_NEG16 16'h8000
`endif

// ==== dcu_pkg.sv ====
// Types and saturation helper of the data computation datapath
// Assumes dcu_consts.svh is on the include path
package dcu_pkg;
`include "dcu_consts.svh"
  typedef enum logic [4:0] {
    DCU_NOP = 5'h00, DCU_SHIFT = 5'h01, DCU_ADD = 5'h02, DCU_SUB = 5'h03,
    DCU_CMP = 5'h04, DCU_RND = 5'h05, DCU_SAT = 5'h06, DCU_AND = 5'h07,
    DCU_OR = 5'h08, DCU_XOR = 5'h09, DCU_ABS = 5'h0a, DCU_DADD = 5'h0b,
    DCU_DSUB = 5'h0c, DCU_BTST = 5'h0d, DCU_BSET = 5'h0e, DCU_BCLR = 5'h0f,
    DCU_BNOT = 5'h10, DCU_MOV = 5'h11, DCU_MAC = 5'h12, DCU_MAS = 5'h13,
    DCU_MPY = 5'h14, DCU_NORM = 5'h15, DCU_EXTR = 5'h16, DCU_EXPD = 5'h17,
    DCU_BCNT = 5'h18, DCU_ROT = 5'h19, DCU_TRN = 5'h1a
  } dcu_op_t;
  typedef enum logic [4:0] {
    DCU_AU_ADD = 5'h00, DCU_AU_SUB = 5'h01, DCU_AU_CMP = 5'h02, DCU_AU_AND = 5'h03,
    DCU_AU_OR = 5'h04, DCU_AU_XOR = 5'h05, DCU_AU_SHL = 5'h06, DCU_AU_SHRA = 5'h07,
    DCU_AU_SHRL = 5'h08, DCU_AU_ABS = 5'h09, DCU_AU_BTST = 5'h0a, DCU_AU_BSET = 5'h0b,
    DCU_AU_BCLR = 5'h0c, DCU_AU_BNOT = 5'h0d, DCU_AU_ROT = 5'h0e, DCU_AU_MOV = 5'h0f,
    DCU_AU_SHFT = 5'h10
  } dcu_au_op_t;
  typedef enum logic [1:0] {
    DCU_SH_ACC = 2'h0, DCU_SH_OP16 = 2'h1, DCU_SH_IMM = 2'h2, DCU_SH_TRN = 2'h3
  } dcu_shsrc_t;
  typedef enum logic [1:0] {
    DCU_B_ACC = 2'h0, DCU_B_SHF = 2'h1, DCU_B_OP16 = 2'h2, DCU_B_TRN = 2'h3
  } dcu_bsel_t;
  typedef enum logic [1:0] {
    DCU_O_IMM = 2'h0, DCU_O_MEM = 2'h1, DCU_O_AREG = 2'h2, DCU_O_PREG = 2'h3
  } dcu_osel_t;

  // Clamp a 41-bit signed sum to 40 bits, then optionally to 32 bits
  function automatic logic [39:0] dcu_sat(input logic [40:0] s, input logic w32);
    logic [39:0] v;
    v = s[39:0];
    if (s[40] != s[39]) v = s[40] ? `DCU_NEG40 : `DCU_POS40;
    if (w32 && (v[39:31] != {9{v[39]}})) v = v[39] ? `DCU_NEG32 : `DCU_POS32;
    return v;
  endfunction : dcu_sat
endpackage : dcu_pkg

// ==== dcu_mac.sv ====
// One multiply-accumulate unit: 17x17 product plus 40-bit add or subtract
// Assumes operands already extended to 17 bits by the caller; purely combinational
`timescale 1ns/1ns
`default_nettype none
module dcu_mac (
  input wire logic [16:0] mul_x,
  input wire logic [16:0] mul_y,
  input wire logic frac_mode,
  input wire logic sub_mode,
  input wire logic sat_en,
  input wire logic sat32,
  input wire logic [39:0] acc_in,
  output logic [39:0] mac_out,
  output logic mac_ovf
);
  logic signed [33:0] prod;
  logic [39:0] prod40;
  logic [40:0] raw;
  assign prod = $signed(mul_x) * $signed(mul_y);
  // Fractional form doubles the product
  assign prod40 = frac_mode ? {{5{prod[33]}}, prod, 1'b0} : {{6{prod[33]}}, prod};
  assign raw = sub_mode ? ({acc_in[39], acc_in} - {prod40[39], prod40})
                        : ({acc_in[39], acc_in} + {prod40[39], prod40});
  assign mac_ovf = (raw[40] != raw[39]) || (sat32 && (raw[39:31] != {9{raw[39]}}));
  assign mac_out = sat_en ? dcu_pkg::dcu_sat(raw, sat32) : raw[39:0];
endmodule : dcu_mac
`default_nettype wire

// ==== dcu_opnd_model.sv ====
// Operand source model: memory or I/O word plus register words
// Assumes the bench loads a word with ld; outputs hold until the next load
`timescale 1ns/1ns
`default_nettype none
module dcu_opnd_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ld,
  input wire logic [15:0] ld_val,
  output logic [15:0] mem16,
  output logic [15:0] areg16,
  output logic [15:0] preg16
);
  logic [15:0] word_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) word_reg <= 16'h0000;
    else if (ld) word_reg <= ld_val;
  end
  assign mem16 = word_reg;
  assign areg16 = ~word_reg;
  assign preg16 = {word_reg[7:0], word_reg[15:8]};
endmodule : dcu_opnd_model
`default_nettype wire

// ==== dcu_datapath_bench.sv ====
// Self-checking bench of the data computation datapath
// Assumes dcu_pkg, dcu_opnd_model and dcu_datapath are compiled first
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module dcu_datapath_bench;
  logic clk_sys = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, au_valid = 1'b0, store_en = 1'b0, ld = 1'b0;
  logic shift_const_en = 1'b0, sz = 1'b0, s32 = 1'b0;
  logic [5:0] bi = 6'h27;
  logic [1:0] dst_sel = 2'h0, srca_sel = 2'h0, srcb_sel = 2'h0, tcnt_sel = 2'h0, store_sel = 2'h0;
  dcu_pkg::dcu_op_t du_op = dcu_pkg::DCU_NOP;
  dcu_pkg::dcu_au_op_t au_op = dcu_pkg::DCU_AU_ADD;
  dcu_pkg::dcu_bsel_t b_sel = dcu_pkg::DCU_B_ACC;
  dcu_pkg::dcu_shsrc_t sh_src = dcu_pkg::DCU_SH_IMM;
  dcu_pkg::dcu_osel_t opnd_sel = dcu_pkg::DCU_O_IMM;
  logic [15:0] imm16 = 16'h0000, au_a = 16'h0000, ld_val = 16'h0000, mem16, areg16, preg16;
  logic [6:0] shift_const = 7'h00;
  logic [3:0][15:0] tregs = '0;
  logic [1:0][15:0] mx = '0, my = '0;
  logic [1:0][1:0] mdst = '0;
  logic [3:0][39:0] acc, ea;
  logic [15:0] tz, to, sd, ash, aur, wd;
  logic sv, arv, atc, dtc, dc;
  logic [3:0] ovf;
  int n_mismatch = 0, total_checks = 0, k, d;
  always #20 clk_sys = ~clk_sys;
  dcu_opnd_model opnd (.clk_sys(clk_sys), .rst_n(rst_n), .ld(ld), .ld_val(ld_val), .mem16(mem16),
    .areg16(areg16), .preg16(preg16));
  dcu_datapath DUT (.clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid), .du_op(du_op), .dst_sel(dst_sel),
    .srca_sel(srca_sel), .srcb_sel(srcb_sel), .b_sel(b_sel), .sh_src(sh_src), .opnd_sel(opnd_sel),
    .imm16(imm16), .mem16(mem16), .areg16(areg16), .preg16(preg16), .shift_const_en(shift_const_en),
    .shift_const(shift_const), .tcnt_sel(tcnt_sel), .temporary_shift_count_regs(tregs), .sat_en(sz),
    .sat32(s32), .bit_idx(bi), .mac_x(mx), .mac_y(my), .mac_dst(mdst), .mac_uns(sz), .mac_frac(sz),
    .store_en(store_en), .store_sel(store_sel), .store_rnd(sz), .store_sat(sz), .au_valid(au_valid),
    .au_op(au_op), .au_a(au_a), .au_bit(4'h0), .ovf_clr(4'h0), .accumulator_bank(acc),
    .transition_reg_zero(tz), .transition_reg_one(to), .store_data(sd), .store_valid(sv),
    .au_shift_data(ash), .au_result(aur), .au_result_valid(arv), .au_tc(atc), .du_tc(dtc),
    .du_carry(dc), .status_ovf(ovf));
  function automatic logic [15:0] opnd_exp(input int s, input logic [15:0] w, input logic [15:0] i);
    case (s)
      0: return i;
      1: return w;
      2: return ~w;
      default: return {w[7:0], w[15:8]};
    endcase
  endfunction : opnd_exp
  task automatic go();
    @(posedge clk_sys);
    #1;
  endtask : go
  task automatic final_report();
    if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  initial begin
    k = $urandom(65971);
    repeat (16) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    `CHK(acc, 160'h0)
    shift_const_en = 1'b1;
    du_op = dcu_pkg::DCU_SHIFT;
    cmd_valid = 1'b1;
    for (d = 0; d < 4; d++) begin
      imm16 = 16'($urandom) & 16'h0fff;
      k = d;
      shift_const = 7'(k);
      dst_sel = 2'(d);
      ea[d] = {24'h000000, imm16} << k;
      go();
      `CHK(acc[d], ea[d])
      `CHK(ash, ea[d][15:0])
    end
    shift_const_en = 1'b0;
    sh_src = dcu_pkg::DCU_SH_ACC;
    dst_sel = 2'h0;
    for (d = 0; d < 4; d++) begin
      tcnt_sel = 2'(d);
      tregs[d] = 16'hffff - 16'(d);
      ea[0] = ea[0] >> (d + 1);
      go();
      `CHK(acc[0], ea[0])
    end
    du_op = dcu_pkg::DCU_ADD;
    {dst_sel, srca_sel, srcb_sel} = 6'h1b;
    go();
    ea[1] = ea[2] + ea[3];
    `CHK(acc[1], ea[1])
    du_op = dcu_pkg::DCU_MPY;
    mx = 32'($urandom);
    my = 32'($urandom);
    mdst = 4'he;
    go();
    cmd_valid = 1'b0;
    ea[2] = $signed(mx[0]) * $signed(my[0]);
    ea[3] = $signed(mx[1]) * $signed(my[1]);
    `CHK(acc, ea)
    store_en = 1'b1;
    store_sel = 2'h2;
    go();
    store_en = 1'b0;
    `CHK({sv, sd}, {1'b1, ea[2][31:16]})
    go();
    `CHK(sv, 1'b0)
    au_valid = 1'b1;
    ld = 1'b1;
    for (d = 0; d < 4; d++) begin
      opnd_sel = dcu_pkg::dcu_osel_t'(d);
      au_a = 16'($urandom);
      imm16 = 16'($urandom);
      ld_val = 16'($urandom);
      wd = mem16;
      go();
      `CHK({arv, aur}, {1'b1, 16'(au_a + opnd_exp(d, wd, imm16))})
    end
    au_valid = 1'b0;
    ld = 1'b0;
    sz = 1'b1;
    s32 = 1'b1;
    cmd_valid = 1'b1;
    du_op = dcu_pkg::DCU_MAC;
    mx = 32'h00008000;
    my = 32'h00008000;
    mdst = 4'hc;
    go();
    ea[0] = 40'h007fffffff;
    `CHK(acc, ea)
    `CHK(ovf, 4'h1)
    sz = 1'b0;
    s32 = 1'b0;
    du_op = dcu_pkg::DCU_MOV;
    b_sel = dcu_pkg::DCU_B_OP16;
    opnd_sel = dcu_pkg::DCU_O_IMM;
    imm16 = 16'($urandom) | 16'h8000;
    dst_sel = 2'h0;
    srca_sel = 2'h0;
    au_valid = 1'b1;
    au_op = dcu_pkg::DCU_AU_CMP;
    au_a = imm16;
    go();
    ea[0] = {24'hffffff, imm16};
    `CHK(acc[0], ea[0])
    `CHK(atc, 1'b1)
    du_op = dcu_pkg::DCU_SHIFT;
    shift_const_en = 1'b1;
    shift_const = 7'h01;
    au_op = dcu_pkg::DCU_AU_SHFT;
    go();
    ea[0] = ea[0] << 1;
    `CHK(acc[0], ea[0])
    `CHK(aur, ea[0][15:0])
    shift_const = 7'h60;
    au_valid = 1'b0;
    go();
    `CHK(acc[0], 40'hffffffffff)
    sh_src = dcu_pkg::DCU_SH_IMM;
    shift_const = 7'h7d;
    imm16 = 16'($urandom);
    go();
    ea[0] = {{24{imm16[15]}}, imm16};
    `CHK(acc[0], ea[0])
    sh_src = dcu_pkg::DCU_SH_ACC;
    shift_const_en = 1'b0;
    tcnt_sel = 2'h2;
    tregs[2] = 16'h0001;
    {dst_sel, srca_sel} = 4'h5;
    go();
    ea[1] = ea[1] << 1;
    `CHK(acc[1], ea[1])
    du_op = dcu_pkg::DCU_DADD;
    b_sel = dcu_pkg::DCU_B_ACC;
    {dst_sel, srca_sel, srcb_sel} = 6'h01;
    wd = ea[0][31:16] + ea[1][31:16];
    go();
    `CHK(acc[0], {{8{wd[15]}}, wd, 16'(ea[0][15:0] + ea[1][15:0])})
    du_op = dcu_pkg::DCU_TRN;
    b_sel = dcu_pkg::DCU_B_OP16;
    dst_sel = 2'h1;
    imm16 = 16'($urandom);
    go();
    du_op = dcu_pkg::DCU_CMP;
    {srca_sel, srcb_sel} = 4'ha;
    b_sel = dcu_pkg::DCU_B_ACC;
    go();
    `CHK({tz, to, dtc}, {16'h0000, imm16, 1'b1})
    du_op = dcu_pkg::DCU_BSET;
    dst_sel = 2'h2;
    go();
    `CHK(acc[2], ea[2] | 40'h8000000000)
    bi = 6'h28;
    du_op = dcu_pkg::DCU_BCLR;
    go();
    `CHK(acc[2], ea[2] | 40'h8000000000)
    du_op = dcu_pkg::DCU_SHIFT;
    sh_src = dcu_pkg::DCU_SH_OP16;
    shift_const_en = 1'b1;
    shift_const = 7'h18;
    imm16 = 16'h8000;
    dst_sel = 2'h0;
    go();
    `CHK(acc[0], 40'h8000000000)
    du_op = dcu_pkg::DCU_ADD;
    {srca_sel, srcb_sel} = 4'h0;
    sz = 1'b1;
    go();
    cmd_valid = 1'b0;
    `CHK(acc[0], 40'h8000000000)
    `CHK(dc, 1'b1)
    final_report();
  end
endmodule : dcu_datapath_bench
`default_nettype wire
